// ===== rtl/acq_scan_trigger_ctrl.sv
`timescale 1ns/1ps
module acq_scan_trigger_ctrl
  import acq_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // host byte bus
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // board pins
  input wire logic ext_trigger,
  input wire logic channel_config_jumper,
  // converter
  output logic adc_start,
  output logic [3:0] adc_channel,
  output logic [RANGE_W-1:0] adc_range,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  // interrupt and dma
  output logic [7:0] irq_line,
  output logic dma_req,
  input wire logic dma_ack,
  input wire logic dma_tc,
  output logic [7:0] dma_data
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
                               input logic w);
    hit = w && (a == off);
  endfunction

  function automatic logic [3:0] next_chan(input logic [3:0] ch, input acq_scan_t s);
    next_chan = (ch == s.scan_stop_channel) ? s.scan_start_channel : ch + 4'h1;
  endfunction

  function automatic acq_trig_t trig_src(input acq_ctrl_t c);
    if (!c.trigger_select_high) trig_src = TRIG_SW;
    else if (!c.trigger_select_low) trig_src = TRIG_EXT;
    else trig_src = TRIG_PACER;
  endfunction

  function automatic logic [7:0] level_lines(input logic [2:0] lvl);
    level_lines = (lvl < 3'd2) ? 8'h00 : 8'(8'h01 << lvl);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ext_s1, ext_s2, ext_s3, cfg_s1, cfg_s2;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      cfg_s1 <= 1'b0;
      cfg_s2 <= 1'b0;
    end else if (ce) begin
      ext_s1 <= ext_trigger;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      cfg_s1 <= channel_config_jumper;
      cfg_s2 <= cfg_s1;
    end
  end

  logic ext_rise;
  assign ext_rise = ext_s2 && !ext_s3;

  // ----------------------------------------------------------------
  // host registers
  // ----------------------------------------------------------------
  logic wr_lo, wr_range, wr_scan, wr_stat, wr_ctrl, wr_pen;
  assign wr_lo = hit(bus_addr, OFF_DATA_LO, bus_wr);
  assign wr_range = hit(bus_addr, OFF_DATA_HI, bus_wr);
  assign wr_scan = hit(bus_addr, OFF_SCAN, bus_wr);
  assign wr_stat = hit(bus_addr, OFF_STATUS, bus_wr);
  assign wr_ctrl = hit(bus_addr, OFF_CTRL, bus_wr);
  assign wr_pen = hit(bus_addr, OFF_PACER_EN, bus_wr);

  acq_scan_t scan_q, scan_d;
  acq_ctrl_t ctrl_q, ctrl_d;
  logic [7:0] pen_q, pen_d;
  logic [RANGE_W-1:0] range_q [NUM_CH];
  logic [RANGE_W-1:0] range_d [NUM_CH];
  logic [RANGE_W-1:0] rng_out_q, rng_out_d;
  logic [3:0] conv_ch_q, conv_ch_d;

  always_comb begin
    scan_d = scan_q;
    ctrl_d = ctrl_q;
    pen_d = pen_q;
    range_d = range_q;
    if (wr_scan) scan_d = acq_scan_t'(bus_wdata);
    if (wr_ctrl) ctrl_d = acq_ctrl_t'(bus_wdata);
    if (wr_pen) pen_d = bus_wdata;
    // range table is pointed at by the start nibble
    if (wr_range) range_d[scan_q.scan_start_channel] = bus_wdata[RANGE_W-1:0];
    rng_out_d = range_q[conv_ch_q];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_q <= acq_scan_t'(SCAN_RST);
      ctrl_q <= acq_ctrl_t'(CTRL_RST);
      pen_q <= PACER_EN_RST;
      range_q <= '{default: RANGE_RST};
      rng_out_q <= RANGE_RST;
    end else if (ce) begin
      scan_q <= scan_d;
      ctrl_q <= ctrl_d;
      pen_q <= pen_d;
      range_q <= range_d;
      rng_out_q <= rng_out_d;
    end
  end

  // ----------------------------------------------------------------
  // pacer
  // ----------------------------------------------------------------
  logic pacer_tick;

  acq_pacer u_pacer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .run(!pen_q[PACER_DIS_BIT]),
    .fast(pen_q[PACER_FAST_BIT]),
    .wr_div1(hit(bus_addr, OFF_PACER_DIV1, bus_wr)),
    .wr_div2(hit(bus_addr, OFF_PACER_DIV2, bus_wr)),
    .wdata(bus_wdata),
    .tick(pacer_tick)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  acq_conv_t conv_q, conv_d;
  acq_dma_t dma_q, dma_d;
  acq_trig_t src;
  logic start_q, start_d, trig_fire, done_ev;
  logic [3:0] ptr_q, ptr_d;
  logic [7:0] lo_q, lo_d, hi_q, hi_d, dmad_q, dmad_d;
  logic valid_q, valid_d, pend_q, pend_d;

  assign src = trig_src(ctrl_q);
  assign trig_fire = ((src == TRIG_SW) && wr_lo)
                  || ((src == TRIG_EXT) && ext_rise)
                  || ((src == TRIG_PACER) && pacer_tick);
  assign done_ev = (conv_q == CONV_BUSY) && adc_done;

  // triggers that arrive while busy are dropped, not queued
  always_comb begin
    conv_d = conv_q;
    start_d = 1'b0;
    ptr_d = ptr_q;
    conv_ch_d = conv_ch_q;
    lo_d = lo_q;
    hi_d = hi_q;
    valid_d = valid_q;
    pend_d = pend_q;
    case (conv_q)
      CONV_IDLE: begin
        if (trig_fire) begin
          conv_d = CONV_BUSY;
          start_d = 1'b1;
          conv_ch_d = ptr_q;
          ptr_d = next_chan(ptr_q, scan_q);
        end
      end
      CONV_BUSY: begin
        if (adc_done) begin
          conv_d = CONV_IDLE;
          lo_d = {adc_result[3:0], conv_ch_q};
          hi_d = adc_result[11:4];
        end
      end
      default: conv_d = CONV_IDLE;
    endcase
    if (wr_scan) ptr_d = bus_wdata[3:0];
    // a completion in the clearing cycle survives the clear
    if (wr_stat) valid_d = 1'b0;
    if (done_ev) valid_d = 1'b1;
    if (wr_stat) pend_d = 1'b0;
    if (ctrl_q.irq_enable_bit && ((done_ev && !ctrl_q.dma_enable_bit)
        || (dma_tc && ctrl_q.dma_enable_bit))) pend_d = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_q <= CONV_IDLE;
      start_q <= 1'b0;
      ptr_q <= 4'h0;
      conv_ch_q <= 4'h0;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      valid_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (ce) begin
      conv_q <= conv_d;
      start_q <= start_d;
      ptr_q <= ptr_d;
      conv_ch_q <= conv_ch_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      valid_q <= valid_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // dma byte pair
  // ----------------------------------------------------------------
  always_comb begin
    dma_d = dma_q;
    dmad_d = dmad_q;
    case (dma_q)
      DMA_IDLE: begin
        if (done_ev && ctrl_q.dma_enable_bit) begin
          dma_d = DMA_REQ_LO;
          dmad_d = {adc_result[3:0], conv_ch_q};
        end
      end
      DMA_REQ_LO: begin
        if (dma_ack) begin
          dma_d = DMA_REQ_HI;
          dmad_d = hi_q;
        end
      end
      DMA_REQ_HI: begin
        if (dma_ack) dma_d = DMA_IDLE;
      end
      default: dma_d = DMA_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_q <= DMA_IDLE;
      dmad_q <= 8'h00;
    end else if (ce) begin
      dma_q <= dma_d;
      dmad_q <= dmad_d;
    end
  end

  // ----------------------------------------------------------------
  // read-back, one cycle after the address
  // ----------------------------------------------------------------
  acq_status_t stat;
  logic [7:0] rd_q, rd_d;

  always_comb begin
    stat.busy = (conv_q == CONV_BUSY);
    stat.spare = 1'b0;
    stat.input_config_flag = cfg_s2;
    stat.data_valid = valid_q;
    stat.next_channel_field = ptr_q;
    case (bus_addr)
      OFF_DATA_LO: rd_d = lo_q;
      OFF_DATA_HI: rd_d = hi_q;
      OFF_SCAN: rd_d = scan_q;
      OFF_STATUS: rd_d = stat;
      OFF_CTRL: rd_d = ctrl_q;
      OFF_PACER_EN: rd_d = pen_q;
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rd_q <= 8'h00;
    else if (ce) rd_q <= rd_d;
  end

  assign bus_rdata = rd_q;
  assign adc_start = start_q;
  assign adc_channel = conv_ch_q;
  assign adc_range = rng_out_q;
  assign irq_line = (pend_q && ctrl_q.irq_enable_bit) ? level_lines(ctrl_q.irq_level_field)
                                                     : 8'h00;
  assign dma_req = (dma_q != DMA_IDLE);
  assign dma_data = dmad_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_start_busy: assert property (@(posedge clk_sys) disable iff (rst)
    adc_start |-> stat.busy && $past(!stat.busy)) else $error("start without busy");

  a_sw_trigger: assert property (@(posedge clk_sys) disable iff (rst)
    ce && wr_lo && !ctrl_q.trigger_select_high && conv_q == CONV_IDLE |=> adc_start)
    else $error("software trigger ignored");

  a_ext_trigger: assert property (@(posedge clk_sys) disable iff (rst)
    ce && ext_rise && src == TRIG_EXT && conv_q == CONV_IDLE |=> adc_start)
    else $error("external edge ignored");

  a_valid_set: assert property (@(posedge clk_sys) disable iff (rst)
    ce && done_ev |=> valid_q) else $error("valid not set on result");

  a_valid_clear: assert property (@(posedge clk_sys) disable iff (rst)
    ce && wr_stat && !done_ev |=> !valid_q) else $error("valid not cleared");

  a_irq_rearm: assert property (@(posedge clk_sys) disable iff (rst)
    ce && wr_stat && !done_ev && !dma_tc |=> irq_line == 8'h00)
    else $error("interrupt not withdrawn");

  a_scan_ptr: assert property (@(posedge clk_sys) disable iff (rst)
    ce && wr_scan |=> stat.next_channel_field == $past(bus_wdata[3:0]))
    else $error("pointer not loaded");

  a_ptr_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    ce && start_d && !wr_scan && ptr_q == scan_q.scan_stop_channel
    |=> ptr_q == scan_q.scan_start_channel) else $error("scan did not wrap");

  a_result_pack: assert property (@(posedge clk_sys) disable iff (rst)
    ce && done_ev |=> lo_q == {$past(adc_result[3:0]), adc_channel}
    && hi_q == $past(adc_result[11:4])) else $error("result packed wrong");

  a_dma_pair: assert property (@(posedge clk_sys) disable iff (rst)
    ce && done_ev && ctrl_q.dma_enable_bit && dma_q == DMA_IDLE
    |=> dma_req && dma_data == lo_q) else $error("dma request missing");

  a_irq_route: assert property (@(posedge clk_sys) disable iff (rst)
    pend_q && ctrl_q.irq_enable_bit && ctrl_q.irq_level_field == 3'b011
    |-> irq_line == 8'h08) else $error("wrong interrupt line");

endmodule

// ===== rtl/acq_pkg.sv
package acq_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int RANGE_W = 4;
  localparam int NUM_CH = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_DATA_LO = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_DATA_HI = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_SCAN = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_PACER_EN = 4'hA;
  localparam logic [ADDR_W-1:0] OFF_PACER_DIV1 = 4'hD;
  localparam logic [ADDR_W-1:0] OFF_PACER_DIV2 = 4'hE;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int PACER_DIS_BIT = 0;
  localparam int PACER_FAST_BIT = 1;
  localparam logic [7:0] SCAN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PACER_EN_RST = 8'h01;
  localparam logic [RANGE_W-1:0] RANGE_RST = 4'h0;
  localparam logic [15:0] PACER_DIV_RST = 16'h0002;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PACER_FAST_NS = 100;
  localparam int PACER_SLOW_NS = 1000;
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PACER_FAST_CYC = PRE_W'(PACER_FAST_NS / CLK_PERIOD_NS);
  localparam logic [PRE_W-1:0] PACER_SLOW_CYC = PRE_W'(PACER_SLOW_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] scan_stop_channel;
    logic [3:0] scan_start_channel;
  } acq_scan_t;

  typedef struct packed {
    logic irq_enable_bit;
    logic [2:0] irq_level_field;
    logic spare;
    logic dma_enable_bit;
    logic trigger_select_high;
    logic trigger_select_low;
  } acq_ctrl_t;

  typedef struct packed {
    logic busy;
    logic spare;
    logic input_config_flag;
    logic data_valid;
    logic [3:0] next_channel_field;
  } acq_status_t;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_BUSY = 2'b10
  } acq_conv_t;

  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_REQ_LO = 3'b010,
    DMA_REQ_HI = 3'b100
  } acq_dma_t;

  typedef enum logic [2:0] {
    TRIG_SW = 3'b001,
    TRIG_EXT = 3'b010,
    TRIG_PACER = 3'b100
  } acq_trig_t;

endpackage

// ===== rtl/acq_pacer.sv
`timescale 1ns/1ps
module acq_pacer
  import acq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic fast,
  input wire logic wr_div1,
  input wire logic wr_div2,
  input wire logic [7:0] wdata,
  // pulse out
  output logic tick
);

  // ----------------------------------------------------------------
  // byte-pair loading
  // ----------------------------------------------------------------
  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic msb,
                                           input logic [7:0] b);
    put_byte = msb ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  logic [PRE_W-1:0] pre_q, pre_d;
  logic [15:0] div1_q, div1_d, div2_q, div2_d;
  logic [15:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
  logic msb1_q, msb1_d, msb2_q, msb2_d;
  logic tick_q, tick_d;

  // ----------------------------------------------------------------
  // two cascaded dividers behind a prescaler
  // ----------------------------------------------------------------
  // a divisor below two behaves as one: a pulse on every prescaler tick
  always_comb begin
    pre_d = pre_q;
    div1_d = div1_q;
    div2_d = div2_q;
    cnt1_d = cnt1_q;
    cnt2_d = cnt2_q;
    msb1_d = msb1_q;
    msb2_d = msb2_q;
    tick_d = 1'b0;
    if (run) begin
      if (pre_q >= (fast ? PACER_FAST_CYC - 7'd1 : PACER_SLOW_CYC - 7'd1)) begin
        pre_d = '0;
        if (cnt1_q <= 16'h0001) begin
          cnt1_d = div1_q;
          if (cnt2_q <= 16'h0001) begin
            cnt2_d = div2_q;
            tick_d = 1'b1;
          end else begin
            cnt2_d = cnt2_q - 16'h0001;
          end
        end else begin
          cnt1_d = cnt1_q - 16'h0001;
        end
      end else begin
        pre_d = pre_q + 7'd1;
      end
    end else begin
      pre_d = '0;
    end
    // writing the high byte restarts that divider
    if (wr_div1) begin
      div1_d = put_byte(div1_q, msb1_q, wdata);
      msb1_d = !msb1_q;
      if (msb1_q) cnt1_d = put_byte(div1_q, 1'b1, wdata);
    end
    if (wr_div2) begin
      div2_d = put_byte(div2_q, msb2_q, wdata);
      msb2_d = !msb2_q;
      if (msb2_q) cnt2_d = put_byte(div2_q, 1'b1, wdata);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      div1_q <= PACER_DIV_RST;
      div2_q <= PACER_DIV_RST;
      cnt1_q <= PACER_DIV_RST;
      cnt2_q <= PACER_DIV_RST;
      msb1_q <= 1'b0;
      msb2_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (ce) begin
      pre_q <= pre_d;
      div1_q <= div1_d;
      div2_q <= div2_d;
      cnt1_q <= cnt1_d;
      cnt2_q <= cnt2_d;
      msb1_q <= msb1_d;
      msb2_q <= msb2_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// ===== verification/acq_far_model.sv
`timescale 1ns/1ps
module acq_far_model #(
  parameter int CONV_CYC = 6,
  parameter int ACK_DLY = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // converter
  input wire logic adc_start,
  input wire logic [3:0] adc_channel,
  output logic adc_done,
  output logic [11:0] adc_result,
  // dma controller
  input wire logic dma_req,
  output logic dma_ack
);
  int conv_q;
  int ack_q;
  logic [11:0] res_q;
  // result valid only in the done cycle; inverse otherwise
  assign adc_result = adc_done ? res_q : ~res_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_q <= 0;
      ack_q <= 0;
      res_q <= 12'h000;
      adc_done <= 1'b0;
      dma_ack <= 1'b0;
    end else begin
      adc_done <= 1'b0;
      dma_ack <= 1'b0;
      if (adc_start) begin
        res_q <= {adc_channel, ~adc_channel, 4'h9};
        conv_q <= CONV_CYC;
      end else if (conv_q == 1) begin
        adc_done <= 1'b1;
        conv_q <= 0;
      end else if (conv_q > 1) begin
        conv_q <= conv_q - 1;
      end
      // slow ack, one byte per request
      if (dma_req && !dma_ack) begin
        ack_q <= ack_q + 1;
        if (ack_q == ACK_DLY) begin
          dma_ack <= 1'b1;
          ack_q <= 0;
        end
      end
    end
  end
endmodule

// ===== verification/acq_scan_trigger_control_tb_top.sv
`timescale 1ns/1ps
module acq_scan_trigger_control_tb_top;
  import acq_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic bus_wr = 1'b0;
  logic ext_trigger = 1'b0;
  logic channel_config_jumper = 1'b1;
  logic dma_tc = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata, dma_data, irq_line, d;
  logic adc_start, adc_done, dma_req, dma_ack;
  logic [3:0] adc_channel, adc_range;
  logic [11:0] adc_result;
  logic [7:0] dq[$];
  int n_mismatch = 0;
  int check_count = 0;
  int i;
  int n_start = 0;
  int seen_start = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (dma_req && dma_ack) dq.push_back(dma_data);
  // start is a one-cycle pulse that ends inside a write call; count it here
  always @(posedge clk_sys) if (adc_start === 1'b1) n_start++;
  acq_scan_trigger_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ext_trigger(ext_trigger),
    .channel_config_jumper(channel_config_jumper), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_range(adc_range), .adc_done(adc_done),
    .adc_result(adc_result), .irq_line(irq_line), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_tc(dma_tc), .dma_data(dma_data));
  acq_far_model i_far (.clk_sys(clk_sys), .rst(rst), .adc_start(adc_start),
    .adc_channel(adc_channel), .adc_done(adc_done), .adc_result(adc_result),
    .dma_req(dma_req), .dma_ack(dma_ack));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic timeout(input string m);
    n_mismatch++;
    $display("Error at %0t: timeout %s", $time, m);
    report_and_stop;
  endtask
  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask
  // extra idle cycle keeps the strobe from toggling twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    step;
    bus_wr = 1'b0;
    step;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    bus_addr = a;
    step;
    step;
    v = bus_rdata;
  endtask
  task automatic wait_start(input int n);
    int k;
    for (k = 0; k < n && n_start == seen_start; k++) step;
    if (k == n) timeout("start");
    seen_start = n_start;
  endtask
  task automatic no_start(input int n);
    repeat (n) begin
      step;
      chk({7'h0, adc_start}, 8'h00, "stray start");
    end
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    for (k = 0; k < 50; k++) begin
      rd(OFF_STATUS, d);
      if (d[b] === v) break;
    end
    if (k == 50) timeout("status");
  endtask
  task automatic ext_pulse;
    ext_trigger = 1'b1;
    step;
    step;
    ext_trigger = 1'b0;
  endtask
  task automatic sw_conv(input logic [3:0] ch, input logic [3:0] rng);
    logic [11:0] r;
    r = {ch, ~ch, 4'h9};
    wr(OFF_DATA_LO, 8'h00);
    wait_start(10);
    chk({4'h0, adc_channel}, {4'h0, ch}, "channel");
    step;
    chk({4'h0, adc_range}, {4'h0, rng}, "range");
    rd(OFF_STATUS, d);
    chk({7'h0, d[7]}, 8'h01, "busy");
    poll(4, 1'b1);
    rd(OFF_DATA_LO, d);
    chk(d, {r[3:0], ch}, "data lo");
    rd(OFF_DATA_HI, d);
    chk(d, r[11:4], "data hi");
    wr(OFF_STATUS, 8'h00);
    rd(OFF_STATUS, d);
    chk({7'h0, d[4]}, 8'h00, "valid clear");
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    // jumper passes two sync stages before status can show it
    step;
    step;
    rd(OFF_STATUS, d);
    chk(d, 8'h20, "status reset");
    rd(OFF_SCAN, d);
    chk(d, SCAN_RST, "scan reset");
    rd(4'h3, d);
    chk(d, 8'h00, "unmapped");
    wr(OFF_SCAN, 8'h55);
    wr(OFF_DATA_HI, 8'h03);
    sw_conv(4'h5, 4'h3);
    wr(OFF_SCAN, 8'h73);
    rd(OFF_SCAN, d);
    chk(d, 8'h73, "scan rw");
    rd(OFF_STATUS, d);
    chk(d, 8'h23, "next channel");
    for (i = 0; i < 7; i++) sw_conv(4'(3 + i % 5), (i % 5 == 2) ? 4'h3 : 4'h0);
    wr(OFF_SCAN, 8'h73);
    rd(OFF_STATUS, d);
    chk({4'h0, d[3:0]}, 8'h03, "pointer reload");
    wr(OFF_CTRL, 8'h01);
    sw_conv(4'h3, 4'h0);
    ext_pulse;
    no_start(10);
    wr(OFF_CTRL, 8'h02);
    ext_pulse;
    wait_start(10);
    poll(4, 1'b1);
    wr(OFF_STATUS, 8'h00);
    for (i = 0; i < 8; i++) begin
      wr(OFF_CTRL, {1'b1, 3'(i), 4'h0});
      wr(OFF_DATA_LO, 8'h00);
      wait_start(10);
      poll(7, 1'b0);
      chk(irq_line, (i >= 2) ? 8'(1 << i) : 8'h00, "irq level");
      wr(OFF_STATUS, 8'h00);
      chk(irq_line, 8'h00, "irq clear");
    end
    wr(OFF_SCAN, 8'h99);
    wr(OFF_CTRL, 8'h04);
    dq.delete();
    wr(OFF_DATA_LO, 8'h00);
    wait_start(10);
    for (i = 0; i < 60 && !(dq.size() == 2 && dma_req === 1'b0); i++) step;
    chk(8'(dq.size()), 8'h02, "dma count");
    chk(dq[0], 8'h99, "dma lo");
    chk(dq[1], 8'h96, "dma hi");
    chk(irq_line, 8'h00, "irq off");
    wr(OFF_CTRL, 8'hB4);
    dma_tc = 1'b1;
    step;
    dma_tc = 1'b0;
    step;
    chk(irq_line, 8'h08, "tc irq");
    wr(OFF_STATUS, 8'h00);
    wr(OFF_CTRL, 8'h03);
    wr(OFF_PACER_DIV1, 8'h02);
    wr(OFF_PACER_DIV1, 8'h00);
    wr(OFF_PACER_DIV2, 8'h02);
    wr(OFF_PACER_DIV2, 8'h00);
    wr(OFF_PACER_EN, 8'h02);
    wait_start(200);
    poll(4, 1'b1);
    wr(OFF_PACER_EN, 8'h01);
    poll(7, 1'b0);
    no_start(100);
    channel_config_jumper = 1'b0;
    repeat (4) step;
    wr(OFF_SCAN, 8'h62);
    rd(OFF_STATUS, d);
    chk(d & 8'hAF, 8'h02, "differential");
    report_and_stop;
  end
endmodule
